// file: verilog/pwt_device.sv
// pwt_device: timing core of a four-channel switch controller
// assumes the host drives direct inputs and chip select synchronous to clk_sys
// Functional notes
// - oc select picks table, slow after reset
// - seven oc steps, slow typical durations
// - cooling select: 00/11 medium, 01 fast, 10 slow
// - six cooling steps, medium typical durations
// - host external clock 7.68 to 30.72 kHz
// - flag clock fail below 2.0 kHz
// - flag clock fail above 200 kHz
// - detector only when pwm on, external clock
// - uncalibrated pwm runs at 120 Hz
// - calibrated pwm within ten percent
// - calibration pulse only from 20 to 200 us
// - duty 0 is off, full is on
// - host keeps pwm at most 1.0 kHz
// - host keeps duty 5 to 98 percent; pwt_host passes any duty unclamped and leaves the range to software
// - input toggle lost after 250 ms
// - external pwm clock arrives on input 0
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pwt_device #(
  parameter int TICK_CYCLES = pwt_pkg::TICK_CYC,
  parameter int CF_LOW_CYCLES = pwt_pkg::CF_LOW_CYC,
  parameter int CAL_MAX_CYCLES = pwt_pkg::CAL_MAX_CYC,
  parameter int TOGGLE_TICKS = pwt_pkg::TOGGLE_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link to host
  pwt_link_if.dev link,
  // protection triggers
  input wire logic oc_start,
  input wire logic cb_start,
  // switch drive
  output logic [3:0] hs_on,
  output logic oc_running,
  output logic cb_running
);
  import pwt_pkg::*;

  logic [15:0] tick_cnt;
  logic tick;
  logic di0_q;
  logic di0_rise;
  logic cf_active;
  logic [15:0] gap;
  logic cf_armed;
  logic cs_q;
  logic [15:0] cal_len;
  logic [15:0] slot_len;
  logic [15:0] slot_cnt;
  logic int_adv;
  logic pwm_adv;
  logic [7:0] pwm_cnt;
  logic pwm_level;
  logic [STEP_W-1:0] oc_len;
  logic [STEP_W-1:0] cb_len;

  // cooling row from the select code
  function automatic logic [1:0] cb_row(input logic [1:0] sel);
    case (sel)
      2'h1: cb_row = 2'h1;
      2'h2: cb_row = 2'h2;
      default: cb_row = 2'h0;
    endcase
  endfunction

  // 10 us tick shared by sequencers and toggle watch
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      tick_cnt <= 16'h0000;
    else if (tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end
  assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

  // edge of the external clock on input 0
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      di0_q <= 1'b0;
    else
      di0_q <= link.direct_input[0];
  end
  assign di0_rise = link.direct_input[0] & ~di0_q;

  // clock-fail detector, period measured between rising edges
  assign cf_active = link.pwm_en & ~link.clock_sel;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      gap <= 16'h0000;
      cf_armed <= 1'b0;
      link.clock_fail <= 1'b0;
    end
    else if (!cf_active)
    begin
      gap <= 16'h0000;
      cf_armed <= 1'b0;
      link.clock_fail <= 1'b0;
    end
    else if (di0_rise)
    begin
      gap <= 16'h0000;
      cf_armed <= 1'b1;
      // edges too close means clock too fast; the first edge after
      // switching on has no period behind it, so it is not judged
      link.clock_fail <= cf_armed && (gap < 16'(CF_HIGH_CYC - 1));
    end
    else if (gap >= 16'(CF_LOW_CYCLES - 1))
      link.clock_fail <= 1'b1;
    else
      gap <= gap + 16'h0001;
  end

  // chip-select low pulse measured for calibration
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cs_q <= 1'b1;
      cal_len <= 16'h0000;
      slot_len <= 16'(PWM_DEF_STEP);
      link.cal_valid <= 1'b0;
    end
    else
    begin
      cs_q <= link.cs_n;
      if (!link.cs_n)
      begin
        if (cal_len != 16'hffff)
          cal_len <= cal_len + 16'h0001;
      end
      else
        cal_len <= 16'h0000;
      // a pulse outside the window leaves the old rate alone
      if (link.cs_n && !cs_q && cal_len >= 16'(CAL_MIN_CYC)
          && cal_len <= 16'(CAL_MAX_CYCLES))
      begin
        slot_len <= cal_len >> CAL_SHIFT;
        link.cal_valid <= 1'b1;
      end
    end
  end

  // internal pwm slot timer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      slot_cnt <= 16'h0000;
    else if (int_adv)
      slot_cnt <= 16'h0000;
    else
      slot_cnt <= slot_cnt + 16'h0001;
  end
  assign int_adv = (slot_cnt >= slot_len - 16'h0001);
  assign pwm_adv = link.clock_sel ? int_adv : di0_rise;

  // pwm counter and compare; duty 256 is full on, 0 full off
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pwm_cnt <= 8'h00;
      pwm_level <= 1'b0;
    end
    else
    begin
      if (pwm_adv)
        pwm_cnt <= pwm_cnt + 8'h01;
      pwm_level <= ({1'b0, pwm_cnt} < link.duty);
    end
  end

  // switch drive: pwm when enabled, else the direct inputs
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      hs_on <= 4'h0;
    else if (link.pwm_en)
      hs_on <= {4{pwm_level}};
    else
      hs_on <= link.direct_input;
  end

  // toggle watch, one per direct input
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_toggle
      logic last;
      logic [15:0] idle;
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          last <= 1'b0;
          idle <= 16'h0000;
          link.toggle_lost[gi] <= 1'b0;
        end
        else
        begin
          last <= link.direct_input[gi];
          if (link.direct_input[gi] != last)
          begin
            idle <= 16'h0000;
            link.toggle_lost[gi] <= 1'b0;
          end
          else if (tick && idle >= 16'(TOGGLE_TICKS - 1))
            link.toggle_lost[gi] <= 1'b1;
          else if (tick)
            idle <= idle + 16'h0001;
        end
      end
    end
  endgenerate

  // step lengths from the selected profile tables
  assign oc_len = OC_TBL[link.overcurrent_profile_sel][link.oc_step];
  assign cb_len = CB_TBL[cb_row(link.cooling_profile_sel)][link.cb_step];

  // over-current and cooling step sequencers
  pwt_step_seq #(
    .STEPS(OC_STEPS)
  ) u_oc_seq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .start(oc_start),
    .step_len(oc_len),
    .step(link.oc_step),
    .running(oc_running),
    .expired(link.oc_expired)
  );
  pwt_step_seq #(
    .STEPS(CB_STEPS)
  ) u_cb_seq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .start(cb_start),
    .step_len(cb_len),
    .step(link.cb_step),
    .running(cb_running),
    .expired(link.cb_expired)
  );
endmodule
`default_nettype wire

// file: verilog/pwt_pkg.sv
// pwt_pkg: shared constants of the protection and pwm timing core
// assumes a 25 MHz system clock on both ends
package pwt_pkg;
  // clock and time base
  localparam int CLK_MHZ = 25;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // clock-fail thresholds: 2.0 kHz and 200 kHz periods
  localparam int CF_LOW_US = 500;
  localparam int CF_LOW_CYC = CF_LOW_US * CLK_MHZ;
  localparam int CF_HIGH_US = 5;
  localparam int CF_HIGH_CYC = CF_HIGH_US * CLK_MHZ;
  // calibration pulse window on chip select
  localparam int CAL_MIN_US = 20;
  localparam int CAL_MAX_US = 200;
  localparam int CAL_MIN_CYC = CAL_MIN_US * CLK_MHZ;
  localparam int CAL_MAX_CYC = CAL_MAX_US * CLK_MHZ;
  localparam int CAL_SHIFT = 2;
  // direct input toggle timeout
  localparam int TOGGLE_MS = 250;
  localparam int TOGGLE_TICKS = TOGGLE_MS * 1000 / TICK_US;
  // pwm: 256 slots a period, default 120 Hz
  localparam int PWM_DEF_HZ = 120;
  localparam int PWM_SLOTS = 256;
  localparam int PWM_DEF_STEP = CLK_MHZ * 1000000 / (PWM_DEF_HZ * PWM_SLOTS);
  // host external clock, 15.36 kHz
  localparam int EXT_CLK_HZ = 15360;
  localparam int EXT_HALF_CYC = CLK_MHZ * 1000000 / (2 * EXT_CLK_HZ);
  // step tables, in 10 us ticks; oc row = profile code
  localparam int OC_STEPS = 7;
  localparam int CB_STEPS = 6;
  localparam int STEP_W = 18;
  localparam logic [STEP_W-1:0] OC_TBL [4][OC_STEPS] = '{
    '{18'h001f4, 18'h000ac, 18'h000c8, 18'h0012c, 18'h001f4, 18'h004c4,
      18'h0116c},
    '{18'h000f8, 18'h00050, 18'h00068, 18'h0009e, 18'h000e0, 18'h00264,
      18'h008ac},
    '{18'h003d4, 18'h00140, 18'h001a4, 18'h00244, 18'h003d4, 18'h00988,
      18'h022d8},
    '{18'h007a8, 18'h00280, 18'h00348, 18'h00488, 18'h007a8, 18'h01310,
      18'h045b0}};
  // cooling rows: 0 medium, 1 fast, 2 slow
  localparam logic [STEP_W-1:0] CB_TBL [3][CB_STEPS] = '{
    '{18'h145c8, 18'h0af00, 18'h0c738, 18'h0e8d0, 18'h11878, 18'h15ec8},
    '{18'h0a348, 18'h05780, 18'h06338, 18'h07148, 18'h08ca0, 18'h0fd20},
    '{18'h28b90, 18'h15d38, 18'h18f38, 18'h1d1a0, 18'h23028, 18'h2bd90}};
  localparam logic [1:0] OC_RESET_SEL = 2'h0;
  localparam logic [1:0] CB_RESET_SEL = 2'h0;
  // host register word addresses
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_DIN = 3'h1;
  localparam logic [2:0] REG_CAL = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_MASK = 3'h4;
  localparam logic [2:0] REG_STATE = 3'h5;
  // ctrl fields
  localparam int CTRL_OC = 0;
  localparam int CTRL_CB = 2;
  localparam int CTRL_PWM_EN = 4;
  localparam int CTRL_CLK_SEL = 5;
  localparam int CTRL_EXT_RUN = 6;
  localparam int CTRL_DUTY = 8;
  // status bits
  localparam int ST_CLK_FAIL = 0;
  localparam int ST_TOGGLE = 1;
  localparam int ST_OC_DONE = 2;
  localparam int ST_CB_DONE = 3;
  localparam int ST_CAL_REF = 4;
  localparam int ST_W = 5;
  // host calibration pulse states
  typedef enum logic {CAL_IDLE, CAL_PULSE} pwt_cal_type;
endpackage

// file: verilog/pwt_link_if.sv
// pwt_link_if: pins and loose configuration bits between host and device
// assumes both ends share clk_sys
`timescale 1ns/10ps
`default_nettype none
interface pwt_link_if;
  // host to device
  logic [3:0] direct_input;
  logic cs_n;
  logic [1:0] overcurrent_profile_sel;
  logic [1:0] cooling_profile_sel;
  logic pwm_en;
  logic clock_sel;
  logic [8:0] duty;
  // device to host
  logic clock_fail;
  logic [3:0] toggle_lost;
  logic [2:0] oc_step;
  logic [2:0] cb_step;
  logic oc_expired;
  logic cb_expired;
  logic cal_valid;
  modport dev (
    input direct_input, cs_n, overcurrent_profile_sel, cooling_profile_sel,
    input pwm_en, clock_sel, duty,
    output clock_fail, toggle_lost, oc_step, cb_step, oc_expired,
    output cb_expired, cal_valid
  );
  modport host (
    output direct_input, cs_n, overcurrent_profile_sel, cooling_profile_sel,
    output pwm_en, clock_sel, duty,
    input clock_fail, toggle_lost, oc_step, cb_step, oc_expired,
    input cb_expired, cal_valid
  );
endinterface
`default_nettype wire

// file: verilog/pwt_step_seq.sv
// pwt_step_seq: walks a fixed number of timed steps on a tick
// assumes step_len is valid for the step currently shown
`timescale 1ns/10ps
`default_nettype none
module pwt_step_seq #(
  parameter int STEPS = 7
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic [pwt_pkg::STEP_W-1:0] step_len,
  // state
  output logic [2:0] step,
  output logic running,
  output logic expired
);
  import pwt_pkg::*;
  logic [STEP_W-1:0] elapsed;

  // restart wins over a running sequence
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      step <= 3'h0;
      running <= 1'b0;
      expired <= 1'b0;
      elapsed <= '0;
    end
    else
    begin
      expired <= 1'b0;
      if (start)
      begin
        step <= 3'h0;
        running <= 1'b1;
        elapsed <= '0;
      end
      else if (running && tick)
      begin
        if (elapsed >= step_len - 1'b1)
        begin
          elapsed <= '0;
          if (step == 3'(STEPS - 1))
          begin
            running <= 1'b0;
            expired <= 1'b1;
          end
          else
            step <= step + 3'h1;
        end
        else
          elapsed <= elapsed + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/pwt_host.sv
// pwt_host: host controller end, registers over avalon-mm
// assumes the device samples its pins on clk_sys
`timescale 1ns/10ps
`default_nettype none
module pwt_host #(
  parameter int EXT_HALF = pwt_pkg::EXT_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // link to device
  pwt_link_if.host link
);
  import pwt_pkg::*;

  logic ack;
  logic acc_wr;
  logic acc_rd;
  logic [31:0] ctrl;
  logic [3:0] din;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] event_set;
  logic cf_q;
  logic tl_q;
  logic cal_ref;
  logic [15:0] div_cnt;
  logic ext_clk;
  pwt_cal_type cal_state;
  logic [15:0] pulse_cnt;
  logic [7:0] cal_us;

  // one wait state, then the access completes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign acc_wr = avs_write & ack;
  assign acc_rd = avs_read & ack;
  assign cal_us = avs_writedata[7:0];

  // control and input registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl <= {28'h0000000, CB_RESET_SEL, OC_RESET_SEL};
      din <= 4'h0;
      mask <= '0;
    end
    else if (acc_wr)
    begin
      if (avs_address == REG_CTRL)
        ctrl <= avs_writedata;
      if (avs_address == REG_DIN)
        din <= avs_writedata[3:0];
      if (avs_address == REG_MASK)
        mask <= avs_writedata[ST_W-1:0];
    end
  end

  // read data loaded during the wait state; unmapped reads give zero
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack)
      case (avs_address)
        REG_CTRL: avs_readdata <= ctrl;
        REG_DIN: avs_readdata <= {28'h0000000, din};
        REG_STATUS: avs_readdata <= 32'(status);
        REG_MASK: avs_readdata <= 32'(mask);
        REG_STATE: avs_readdata <= {19'h00000, link.cal_valid,
          link.cb_step, link.oc_step, link.toggle_lost, link.clock_fail,
          cal_state == CAL_PULSE};
        default: avs_readdata <= 32'h00000000;
      endcase
  end

  // device events; set wins over the read clear
  assign event_set[ST_CLK_FAIL] = link.clock_fail & ~cf_q;
  assign event_set[ST_TOGGLE] = (|link.toggle_lost) & ~tl_q;
  assign event_set[ST_OC_DONE] = link.oc_expired;
  assign event_set[ST_CB_DONE] = link.cb_expired;
  assign event_set[ST_CAL_REF] = cal_ref;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      status <= '0;
      cf_q <= 1'b0;
      tl_q <= 1'b0;
    end
    else
    begin
      cf_q <= link.clock_fail;
      tl_q <= |link.toggle_lost;
      // only bits handed out in the read data are cleared, so an event
      // landing during the wait state is not lost
      if (acc_rd && avs_address == REG_STATUS)
        status <= (status & ~avs_readdata[ST_W-1:0]) | event_set;
      else
        status <= status | event_set;
    end
  end
  assign irq = |(status & mask);

  // external pwm clock divider, toggling every EXT_HALF cycles
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      div_cnt <= 16'h0000;
      ext_clk <= 1'b0;
    end
    else if (div_cnt >= 16'(EXT_HALF - 1))
    begin
      div_cnt <= 16'h0000;
      ext_clk <= ~ext_clk;
    end
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // calibration pulse on chip select; out-of-window lengths refused
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cal_state <= CAL_IDLE;
      pulse_cnt <= 16'h0000;
      cal_ref <= 1'b0;
    end
    else
    begin
      cal_ref <= 1'b0;
      case (cal_state)
        CAL_IDLE:
          if (acc_wr && avs_address == REG_CAL)
          begin
            if (cal_us >= 8'(CAL_MIN_US) && cal_us <= 8'(CAL_MAX_US))
            begin
              pulse_cnt <= 16'(cal_us * CLK_MHZ);
              cal_state <= CAL_PULSE;
            end
            else
              cal_ref <= 1'b1;
          end
        CAL_PULSE:
          if (pulse_cnt <= 16'h0001)
            cal_state <= CAL_IDLE;
          else
            pulse_cnt <= pulse_cnt - 16'h0001;
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  // pin drive; duty range is software's to keep
  assign link.cs_n = (cal_state != CAL_PULSE);
  assign link.direct_input = {din[3:1],
    ctrl[CTRL_EXT_RUN] ? ext_clk : din[0]};
  assign link.overcurrent_profile_sel = ctrl[CTRL_OC+1:CTRL_OC];
  assign link.cooling_profile_sel = ctrl[CTRL_CB+1:CTRL_CB];
  assign link.pwm_en = ctrl[CTRL_PWM_EN];
  assign link.clock_sel = ctrl[CTRL_CLK_SEL];
  assign link.duty = ctrl[CTRL_DUTY+8:CTRL_DUTY];
endmodule
`default_nettype wire

// file: bench/pwt_link_monitor.sv
// pwt_link_monitor: timing checks on the link between host and device
// assumes one clk_sys domain and a synchronous active low rst_n
`timescale 1ns/10ps
`default_nettype none
module pwt_link_monitor #(
  parameter int CF_LOW_CYCLES = 300,
  parameter int TOGGLE_CYC = 100
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host to device
  input wire logic [3:0] direct_input,
  input wire logic cs_n,
  input wire logic pwm_en,
  input wire logic clock_sel,
  // device to host
  input wire logic clock_fail,
  input wire logic [3:0] toggle_lost,
  input wire logic [2:0] oc_step,
  input wire logic [2:0] cb_step,
  input wire logic oc_expired,
  input wire logic cal_valid
);
  logic active;
  logic [9:0] gap;
  logic [12:0] low_len;
  logic [11:0] still;
  default clocking mon_clk @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // detector only judged with pwm on and the external clock chosen
  assign active = pwm_en && !clock_sel;
  // cycles since a rise of input 0; 3ff marks no rise seen while active
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !active)
      gap <= 10'h3ff;
    else if ($rose(direct_input[0]))
      gap <= 10'h0;
    else if (gap < 10'h3e8)
      gap <= gap + 10'h1;
  end
  // length of the running chip select low pulse
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || cs_n)
      low_len <= 13'h0;
    else if (low_len != 13'h1fff)
      low_len <= low_len + 13'h1;
  end
  // quiet time on input 1, saturating so it never wraps
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || $changed(direct_input[1]))
      still <= 12'h0;
    else if (still != 12'hfff)
      still <= still + 12'h1;
  end
  sequence s_good_pulse;
    $rose(cs_n) && low_len >= 13'h1f4 && low_len <= 13'h1388;
  endsequence
  sequence s_oc_advance;
    $changed(oc_step) && oc_step != 3'h0;
  endsequence
  a_oc_exp_pulse: assert property (oc_expired |=> !oc_expired)
    else $error("oc expired pulse longer than one cycle");
  a_oc_step_max: assert property (oc_step <= 3'h6)
    else $error("oc step beyond the seventh");
  a_cb_step_max: assert property (cb_step <= 3'h5)
    else $error("cooling step beyond the sixth");
  a_oc_walk_order: assert property (s_oc_advance |->
    oc_step == 3'($past(oc_step) + 3'h1))
    else $error("oc step skipped");
  a_oc_last_step: assert property ($rose(oc_expired) |->
    $past(oc_step) == 3'h6)
    else $error("oc expired before the last step");
  a_cf_idle: assert property (!active [*2] |-> !clock_fail)
    else $error("clock fail while detector off");
  a_cf_slow: assert property (gap > 10'(CF_LOW_CYCLES + 4) &&
    gap != 10'h3ff |-> clock_fail)
    else $error("missing clock not flagged");
  a_cf_fast: assert property (active && $rose(direct_input[0]) &&
    gap < 10'h6e |=> clock_fail)
    else $error("fast clock not flagged");
  a_cal_sticky: assert property (cal_valid |=> cal_valid)
    else $error("calibration valid dropped");
  a_cal_accept: assert property (s_good_pulse |-> ##[1:2] cal_valid)
    else $error("good calibration pulse not taken");
  a_toggle_set: assert property (still > 12'(TOGGLE_CYC + 10) |->
    toggle_lost[1])
    else $error("stopped input not flagged");
  a_toggle_clear: assert property ($changed(direct_input[1]) |->
    ##[1:2] !toggle_lost[1])
    else $error("toggle lost not cleared by change");
endmodule
`default_nettype wire

// file: bench/protection_and_pwm_timing_test.sv
// protection_and_pwm_timing_test: host and device joined on one link
// assumes pwt_pkg, the link interface, both ends and the monitor compiled
`timescale 1ns/10ps
`default_nettype none
module protection_and_pwm_timing_test;
  import pwt_pkg::*;
  localparam int TK = 5;
  localparam int LIMIT = 100000;
  logic clk_sys;
  logic rst_n;
  logic [2:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic oc_start;
  logic cb_start;
  logic [3:0] hs_on;
  logic oc_running;
  logic cb_running;
  logic [31:0] q;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  int bad;
  int fast_ticks [7] = '{248, 80, 104, 158, 224, 612, 2220};
  int first_ticks [4] = '{500, 248, 980, 1960};
  int cal_us [4] = '{19, 201, 200, 20};
  pwt_link_if pwt_link_if_i ();
  // short tick and timeouts keep the run small
  pwt_device #(.TICK_CYCLES(TK), .CF_LOW_CYCLES(300),
    .CAL_MAX_CYCLES(CAL_MAX_CYC), .TOGGLE_TICKS(20)) pwt_device_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .link(pwt_link_if_i),
    .oc_start(oc_start), .cb_start(cb_start), .hs_on(hs_on),
    .oc_running(oc_running), .cb_running(cb_running));
  // 200 cycle external period sits between both detector limits
  pwt_host #(.EXT_HALF(100)) pwt_host_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(pwt_link_if_i));
  pwt_link_monitor #(.CF_LOW_CYCLES(300), .TOGGLE_CYC(20 * TK))
    pwt_link_monitor_i (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .direct_input(pwt_link_if_i.direct_input), .cs_n(pwt_link_if_i.cs_n),
    .pwm_en(pwt_link_if_i.pwm_en), .clock_sel(pwt_link_if_i.clock_sel),
    .clock_fail(pwt_link_if_i.clock_fail),
    .toggle_lost(pwt_link_if_i.toggle_lost),
    .oc_step(pwt_link_if_i.oc_step), .cb_step(pwt_link_if_i.cb_step),
    .oc_expired(pwt_link_if_i.oc_expired),
    .cal_valid(pwt_link_if_i.cal_valid));
  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a,
    input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  // tol 0 means exact four-state match
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
    input int tol);
    n_compared++;
    if ((tol == 0) ? (got !== exp) : ($isunknown(got) ||
      got > exp + tol || got + tol < exp))
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cycle count by nba so reads after an edge never race it
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      errors++;
      report_and_stop();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    oc_start = 1'b0;
    cb_start = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(REG_CTRL, q);
    check(q, 32'h0, 0);
    rd(REG_STATE, q);
    check(q, 32'h0, 0);
    rd(3'h6, q);
    check(q, 32'h0, 0);
    // first step of each profile, whole walk for fast; restart mid-run
    for (int c = 0; c < 4; c++)
    begin
      wr(REG_CTRL, 32'(c));
      oc_start <= 1'b1;
      @(posedge clk_sys);
      oc_start <= 1'b0;
      for (int s = 0; s < ((c == 1) ? 7 : 1); s++)
      begin
        t0 = cyc;
        @(posedge clk_sys iff (pwt_link_if_i.oc_step !== 3'(s) ||
          pwt_link_if_i.oc_expired === 1'b1));
        check(cyc - t0, ((c == 1) ? fast_ticks[s] : first_ticks[c]) * TK,
          TK + 1);
      end
    end
    check(oc_running, 1'b1, 0);
    cb_start <= 1'b1;
    @(posedge clk_sys);
    cb_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(cb_running, 1'b1, 0);
    // calibration: out of window refused, both boundaries taken
    rd(REG_STATUS, q);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CAL, 32'(cal_us[i]));
      if (i < 2)
      begin
        repeat (10) @(posedge clk_sys);
        check(pwt_link_if_i.cs_n, 1'b1, 0);
        rd(REG_STATUS, q);
        check(q[ST_CAL_REF], 1'b1, 0);
        rd(REG_STATE, q);
        check(q[12], 1'b0, 0);
      end
      else
      begin
        @(posedge clk_sys iff pwt_link_if_i.cs_n === 1'b0);
        t0 = cyc;
        @(posedge clk_sys iff pwt_link_if_i.cs_n === 1'b1);
        check(cyc - t0, cal_us[i] * CLK_MHZ, 2);
        repeat (2) @(posedge clk_sys);
        check(pwt_link_if_i.cal_valid, 1'b1, 0);
      end
    end
    // duty 8 on the calibrated slot, then full off and full on
    wr(REG_CTRL, 32'h830);
    // let hs_on follow the pwm level before timing a whole pulse
    repeat (3) @(posedge clk_sys);
    @(posedge clk_sys iff hs_on[0] === 1'b0);
    @(posedge clk_sys iff hs_on[0] === 1'b1);
    t0 = cyc;
    @(posedge clk_sys iff hs_on[0] === 1'b0);
    check(cyc - t0, 8 * (CAL_MIN_CYC >> CAL_SHIFT), 2);
    for (int i = 0; i < 2; i++)
    begin
      wr(REG_CTRL, (i == 1) ? 32'h10030 : 32'h30);
      repeat (3) @(posedge clk_sys);
      bad = 0;
      repeat (300)
      begin
        @(posedge clk_sys);
        bad += int'(hs_on !== ((i == 1) ? 4'hf : 4'h0));
      end
      check(bad, 32'h0, 0);
    end
    // external clock good, too fast, good again, then stopped
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h50);
    repeat (1000) @(posedge clk_sys);
    check(pwt_link_if_i.clock_fail, 1'b0, 0);
    wr(REG_CTRL, 32'h10);
    for (int i = 0; i < 6; i++)
      wr(REG_DIN, (i % 2 == 0) ? 32'h1 : 32'h0);
    check(pwt_link_if_i.clock_fail, 1'b1, 0);
    wr(REG_CTRL, 32'h50);
    repeat (600) @(posedge clk_sys);
    check(pwt_link_if_i.clock_fail, 1'b0, 0);
    rd(REG_STATUS, q);
    wr(REG_CTRL, 32'h10);
    repeat (400) @(posedge clk_sys);
    check(pwt_link_if_i.clock_fail, 1'b1, 0);
    check(irq, 1'b1, 0);
    wr(REG_MASK, 32'h0);
    check(irq, 1'b0, 0);
    wr(REG_MASK, 32'h1);
    check(irq, 1'b1, 0);
    rd(REG_STATUS, q);
    check(q[ST_CLK_FAIL], 1'b1, 0);
    check(irq, 1'b0, 0);
    wr(REG_CTRL, 32'h30);
    repeat (3) @(posedge clk_sys);
    check(pwt_link_if_i.clock_fail, 1'b0, 0);
    // input 1 changes once, then must be flagged after the timeout
    wr(REG_DIN, 32'h2);
    repeat (2) @(posedge clk_sys);
    check(pwt_link_if_i.toggle_lost[1], 1'b0, 0);
    t0 = cyc;
    @(posedge clk_sys iff pwt_link_if_i.toggle_lost[1] === 1'b1);
    check(cyc - t0, 20 * TK - 2, TK + 3);
    report_and_stop();
  end
endmodule
`default_nettype wire
